// ### motor_cmd_pkg.sv
`default_nettype none

package motor_cmd_pkg;

    // =========================================================================
    // Remote I/O input word layout.
    localparam int IN_START = 0;
    localparam int IN_RUN_POS = 1;
    localparam int IN_RUN_NEG = 2;
    localparam int IN_HOME = 3;
    localparam int IN_STOP = 4;
    localparam int IN_EXCITE = 5;
    localparam int IN_SEL_LSB = 8;
    localparam int SEL_W = 6;

    // =========================================================================
    // Remote I/O output word layout.
    localparam int OUT_START_ECHO = 0;
    localparam int OUT_STEP_LOSS = 1;
    localparam int OUT_MOTION = 2;
    localparam int OUT_HOME_DONE = 3;
    localparam int OUT_ALARM8 = 4;
    localparam int OUT_READY = 5;
    localparam int OUT_AREA = 7;
    localparam int OUT_SEL_LSB = 8;
    localparam int OUT_WARNING = 14;
    localparam int OUT_ALARM16 = 15;

    // =========================================================================
    // Remote register fields and reset values.
    localparam int CODE_W = 14;
    localparam int DATA_W = 32;
    localparam logic [13:0] STOP_ACTION_CODE = 14'h0C02;
    localparam logic [5:0] SEL_SEQUENTIAL = 6'h00;
    localparam logic [15:0] IO_OUT_RST = 16'h0000;

    // Motion modes of the profile generator behind this port.
    typedef enum logic [2:0] {
        MODE_IDLE,
        MODE_POSITION,
        MODE_SEQUENCE,
        MODE_CONT_POS,
        MODE_CONT_NEG,
        MODE_HOMING
    } motion_mode_t;

endpackage

`default_nettype wire

// ### motor_remote_io_command_port.sv
`timescale 1ns/1ps
`default_nettype none

module motor_remote_io_command_port (
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Remote I/O words from and to the controller.
    input wire logic [15:0] io_word_in,
    output logic [15:0] io_word_out,
    // Remote register command from the controller.
    input wire logic [13:0] cmd_code_in,
    input wire logic cmd_trigger_in,
    input wire logic [31:0] cmd_data_in,
    // Remote register response to the controller.
    output logic [13:0] rsp_code_out,
    output logic cmd_done_trigger_out,
    output logic rsp_error_out,
    output logic [31:0] rsp_data_out,
    // Command execution handshake with the parameter engine.
    output logic exec_req_out,
    output logic [13:0] exec_code_out,
    output logic [31:0] exec_wdata_out,
    input wire logic exec_done_in,
    input wire logic exec_error_in,
    input wire logic [31:0] exec_rdata_in,
    // Configuration and drive state.
    input wire logic excite_invert_in,
    input wire logic [1:0] stop_action_in,
    input wire logic ready_in,
    input wire logic moving_in,
    input wire logic home_finished_in,
    input wire logic step_loss_in,
    input wire logic alarm_flag_in,
    input wire logic warning_flag_in,
    input wire logic in_area_in,
    // Motion commands to the profile generator.
    output logic excite_out,
    output logic stop_out,
    output logic [1:0] stop_method_out,
    output motor_cmd_pkg::motion_mode_t mode_out,
    output logic mode_start_out,
    output logic [5:0] data_select_out
);

    // All checks below sample on the rising clock and pause in reset.
    default clocking chk_clk @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);

    // =========================================================================
    // Input decoding.

    // Bit fields of the incoming word, named for the priority logic.
    wire logic start_bit = io_word_in[motor_cmd_pkg::IN_START];
    wire logic run_positive = io_word_in[motor_cmd_pkg::IN_RUN_POS];
    wire logic run_negative = io_word_in[motor_cmd_pkg::IN_RUN_NEG];
    wire logic home_bit = io_word_in[motor_cmd_pkg::IN_HOME];
    wire logic stop_bit = io_word_in[motor_cmd_pkg::IN_STOP];
    wire logic excite_bit = io_word_in[motor_cmd_pkg::IN_EXCITE];
    // Operation data number, lowest select bit least significant.
    wire logic [5:0] data_select =
        io_word_in[motor_cmd_pkg::IN_SEL_LSB +: motor_cmd_pkg::SEL_W];

    // =========================================================================
    // Edge detection against the previous cycle.

    logic home_q;
    logic start_q;
    logic cmd_trigger_q;

    // Plain one-cycle history; inputs are already synchronous.
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            home_q <= 1'b0;
            start_q <= 1'b0;
            cmd_trigger_q <= 1'b0;
        end else begin
            home_q <= home_bit;
            start_q <= start_bit;
            cmd_trigger_q <= cmd_trigger_in;
        end
    end

    wire logic home_rise = home_bit & ~home_q;
    wire logic start_rise = start_bit & ~start_q;
    wire logic cmd_trigger_rise = cmd_trigger_in & ~cmd_trigger_q;

    // =========================================================================
    // Motion command priority.

    // One direction only runs; both together or neither means no run.
    wire logic run_one = run_positive ^ run_negative;
    wire logic energised = excite_bit ^ excite_invert_in;
    // Motion is allowed only when energised, not stopped and ready.
    wire logic may_move = energised & ~stop_bit & ready_in;

    motor_cmd_pkg::motion_mode_t mode_q;
    motor_cmd_pkg::motion_mode_t mode_d;
    logic mode_start_q;
    logic mode_start_d;

    // Highest priority first: excitation, stop, direction, home, start.
    always_comb begin
        mode_d = mode_q;
        mode_start_d = 1'b0;
        if (!may_move) begin
            mode_d = motor_cmd_pkg::MODE_IDLE;
        end else if (run_one) begin
            mode_d = run_positive ? motor_cmd_pkg::MODE_CONT_POS
                                  : motor_cmd_pkg::MODE_CONT_NEG;
            mode_start_d = (mode_q != mode_d);
        end else if (mode_q == motor_cmd_pkg::MODE_CONT_POS ||
                     mode_q == motor_cmd_pkg::MODE_CONT_NEG) begin
            mode_d = motor_cmd_pkg::MODE_IDLE;
        end else if (home_rise) begin
            mode_d = motor_cmd_pkg::MODE_HOMING;
            mode_start_d = 1'b1;
        end else if (start_rise) begin
            mode_d = (data_select == motor_cmd_pkg::SEL_SEQUENTIAL)
                     ? motor_cmd_pkg::MODE_SEQUENCE
                     : motor_cmd_pkg::MODE_POSITION;
            mode_start_d = 1'b1;
        end else if (mode_q != motor_cmd_pkg::MODE_IDLE && !moving_in &&
                     !mode_start_q) begin
            // Point moves end when the generator reports standstill.
            mode_d = motor_cmd_pkg::MODE_IDLE;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            mode_q <= motor_cmd_pkg::MODE_IDLE;
            mode_start_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            mode_start_q <= mode_start_d;
        end
    end

    // Drive commands are registered so they cannot glitch mid-cycle.
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            excite_out <= 1'b0;
            stop_out <= 1'b0;
            stop_method_out <= 2'h0;
            data_select_out <= 6'h00;
        end else begin
            excite_out <= energised;
            stop_out <= stop_bit;
            stop_method_out <= stop_action_in;
            data_select_out <= data_select;
        end
    end

    assign mode_out = mode_q;
    assign mode_start_out = mode_start_q;

    // =========================================================================
    // Status word back to the controller.

    logic [15:0] io_out_d;

    // Alarm appears in bit 4 of the short form and bit 15 of the long one.
    always_comb begin
        io_out_d = motor_cmd_pkg::IO_OUT_RST;
        io_out_d[motor_cmd_pkg::OUT_START_ECHO] = start_bit;
        io_out_d[motor_cmd_pkg::OUT_STEP_LOSS] = step_loss_in;
        io_out_d[motor_cmd_pkg::OUT_MOTION] = moving_in;
        io_out_d[motor_cmd_pkg::OUT_HOME_DONE] = home_finished_in;
        io_out_d[motor_cmd_pkg::OUT_ALARM8] = alarm_flag_in;
        io_out_d[motor_cmd_pkg::OUT_READY] = ready_in;
        io_out_d[motor_cmd_pkg::OUT_AREA] = in_area_in;
        io_out_d[motor_cmd_pkg::OUT_SEL_LSB +: motor_cmd_pkg::SEL_W] =
            data_select;
        io_out_d[motor_cmd_pkg::OUT_WARNING] = warning_flag_in;
        io_out_d[motor_cmd_pkg::OUT_ALARM16] = alarm_flag_in;
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            io_word_out <= motor_cmd_pkg::IO_OUT_RST;
        end else begin
            io_word_out <= io_out_d;
        end
    end

    // =========================================================================
    // Remote register handshake.

    logic busy_q;
    logic [13:0] code_q;
    logic [31:0] wdata_q;

    // A new trigger edge is latched only when idle; the controller waits.
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            busy_q <= 1'b0;
            code_q <= 14'h0000;
            wdata_q <= 32'h0000_0000;
        end else if (cmd_trigger_rise && !busy_q) begin
            busy_q <= 1'b1;
            code_q <= cmd_code_in;
            wdata_q <= cmd_data_in;
        end else if (busy_q && exec_done_in) begin
            busy_q <= 1'b0;
        end
    end

    assign exec_req_out = busy_q;
    assign exec_code_out = code_q;
    assign exec_wdata_out = wdata_q;

    // Response holds until the next command completes; only the done trigger clears at the next taken trigger edge.
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            rsp_code_out <= 14'h0000;
            cmd_done_trigger_out <= 1'b0;
            rsp_error_out <= 1'b0;
            rsp_data_out <= 32'h0000_0000;
        end else if (cmd_trigger_rise && !busy_q) begin
            cmd_done_trigger_out <= 1'b0;
        end else if (busy_q && exec_done_in) begin
            rsp_code_out <= code_q;
            cmd_done_trigger_out <= 1'b1;
            rsp_error_out <= exec_error_in;
            rsp_data_out <= exec_rdata_in;
        end
    end

    // =========================================================================
    // Checks.

    sequence s_cmd_trigger_taken;
        cmd_trigger_rise && !busy_q;
    endsequence

    sequence s_exec_done;
        busy_q && exec_done_in;
    endsequence

    a_code_echo: assert property (
        s_exec_done |=> rsp_code_out == $past(code_q))
        else $error("response code differs from command code");

    a_done_low: assert property (
        s_cmd_trigger_taken |=> !cmd_done_trigger_out throughout busy_q[*1])
        else $error("done trigger high while command runs");

    a_busy_done_low: assert property (
        busy_q |-> !cmd_done_trigger_out)
        else $error("done trigger high while busy");

    a_done_high: assert property (
        s_exec_done |=> cmd_done_trigger_out && !busy_q)
        else $error("done trigger not raised at completion");

    a_result_flag: assert property (
        s_exec_done |=> rsp_error_out == $past(exec_error_in))
        else $error("result flag wrong");

    // The whole word is kept, so byte 0 stays in bits 7 to 0.
    a_data_order: assert property (
        s_exec_done |=> rsp_data_out == $past(exec_rdata_in))
        else $error("response data wrong");

    a_take_latch: assert property (
        s_cmd_trigger_taken |=> busy_q && code_q == $past(cmd_code_in))
        else $error("trigger edge not taken");

    // A second edge during a command must leave the latched code alone.
    a_busy_refuse: assert property (
        cmd_trigger_rise && busy_q |=> code_q == $past(code_q))
        else $error("trigger edge taken while busy");

    a_no_move_unready: assert property (
        !ready_in |=> mode_q == motor_cmd_pkg::MODE_IDLE && !mode_start_q)
        else $error("motion while not ready");

    a_stop_halts: assert property (
        stop_bit |=> mode_q == motor_cmd_pkg::MODE_IDLE && !mode_start_q)
        else $error("motion while stop is set");

    a_stop_drive: assert property (
        ##1 stop_out == $past(stop_bit) &&
        stop_method_out == $past(stop_action_in))
        else $error("stop command not passed on");

    a_excite_drive: assert property (
        ##1 excite_out == ($past(excite_bit) ^ $past(excite_invert_in)))
        else $error("excitation drive wrong");

    a_home_edge: assert property (
        may_move && !run_one && home_rise && !$past(run_one)
        |=> mode_q == motor_cmd_pkg::MODE_HOMING)
        else $error("homing not started on edge");

    a_seq_start: assert property (
        mode_start_q && mode_q == motor_cmd_pkg::MODE_SEQUENCE
        |-> $past(data_select) == motor_cmd_pkg::SEL_SEQUENTIAL)
        else $error("sequential mode without data number 0");

    a_run_one_dir: assert property (
        may_move && run_positive && !run_negative
        |=> mode_q == motor_cmd_pkg::MODE_CONT_POS)
        else $error("forward run not started");

    a_both_dirs: assert property (
        run_positive && run_negative |=>
        mode_q != motor_cmd_pkg::MODE_CONT_POS &&
        mode_q != motor_cmd_pkg::MODE_CONT_NEG)
        else $error("continuous run with both directions");

    a_status_echo: assert property (
        ##1 io_word_out[motor_cmd_pkg::OUT_START_ECHO] == $past(start_bit))
        else $error("start echo mismatch");

    a_select_echo: assert property (
        ##1 io_word_out[motor_cmd_pkg::OUT_SEL_LSB +: motor_cmd_pkg::SEL_W]
        == $past(data_select))
        else $error("select echo mismatch");

    a_flag_bits: assert property (
        ##1 io_word_out[motor_cmd_pkg::OUT_WARNING] == $past(warning_flag_in)
        && io_word_out[motor_cmd_pkg::OUT_ALARM16] == $past(alarm_flag_in))
        else $error("warning or alarm bit wrong");

    a_area_bit: assert property (
        ##1 io_word_out[motor_cmd_pkg::OUT_AREA] == $past(in_area_in))
        else $error("area bit wrong");

endmodule // motor_remote_io_command_port

`default_nettype wire

// ### param_engine_model.sv
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// Parameter engine stand-in
// Each request is answered after LAT+1 cycles with a one-cycle done pulse.
// Outside the pulse the answer lines toggle, so late sampling shows up.
module param_engine_model #(
    parameter int LAT = 3
) (
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Request side.
    input wire logic req_in,
    input wire logic [13:0] code_in,
    input wire logic [31:0] wdata_in,
    // Answer side.
    output logic done_out,
    output logic error_out,
    output logic [31:0] rdata_out
);
    logic [7:0] wait_q;

    // Codes with the top bit set fail; read data is write data plus code.
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            wait_q <= 8'h00;
            done_out <= 1'b0;
            error_out <= 1'b0;
            rdata_out <= 32'h00000000;
        end else begin
            done_out <= 1'b0;
            error_out <= ~error_out;
            rdata_out <= ~rdata_out;
            if (req_in && !done_out) begin
                wait_q <= wait_q + 8'h01;
                if (wait_q == 8'(LAT)) begin
                    wait_q <= 8'h00;
                    done_out <= 1'b1;
                    error_out <= code_in[13];
                    rdata_out <= wdata_in + {18'h0, code_in};
                end
            end
        end
    end
endmodule // param_engine_model

`default_nettype wire

// ### motor_remote_io_command_port_tb.sv
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// Testbench
module motor_remote_io_command_port_tb;
    localparam logic [15:0] BASE = 16'h0020;
    logic mclk = 1'b0, rst, invert, ready, moving, home_fin, step_loss;
    logic alarm, warning, in_area, cmd_cmd_trigger, ex_done, ex_err, ex_req;
    logic done_cmd_trigger, rsp_err, excite, stop_o, mstart;
    logic [15:0] io_word, io_out;
    logic [13:0] cmd_code, rsp_code, ex_code;
    logic [31:0] cmd_data, rsp_data, ex_wdata, ex_rdata;
    logic [1:0] stop_act, stop_meth;
    logic [5:0] dsel;
    motor_cmd_pkg::motion_mode_t mode, pmode;
    int err_total = 0;
    int cmp_count = 0;
    int pulses;

    // The clock toggles every half period of 100 ns.
    always #50 mclk = ~mclk;

    motor_remote_io_command_port u_motor_remote_io_command_port (
        .mclk_in(mclk), .sys_rst_in(rst), .io_word_in(io_word),
        .io_word_out(io_out), .cmd_code_in(cmd_code),
        .cmd_trigger_in(cmd_cmd_trigger), .cmd_data_in(cmd_data),
        .rsp_code_out(rsp_code), .cmd_done_trigger_out(done_cmd_trigger),
        .rsp_error_out(rsp_err), .rsp_data_out(rsp_data),
        .exec_req_out(ex_req), .exec_code_out(ex_code),
        .exec_wdata_out(ex_wdata), .exec_done_in(ex_done),
        .exec_error_in(ex_err), .exec_rdata_in(ex_rdata),
        .excite_invert_in(invert), .stop_action_in(stop_act),
        .ready_in(ready), .moving_in(moving), .home_finished_in(home_fin),
        .step_loss_in(step_loss), .alarm_flag_in(alarm),
        .warning_flag_in(warning), .in_area_in(in_area),
        .excite_out(excite), .stop_out(stop_o), .stop_method_out(stop_meth),
        .mode_out(mode), .mode_start_out(mstart), .data_select_out(dsel));

    param_engine_model u_param_engine_model (
        .mclk_in(mclk), .sys_rst_in(rst), .req_in(ex_req),
        .code_in(ex_code), .wdata_in(ex_wdata), .done_out(ex_done),
        .error_out(ex_err), .rdata_out(ex_rdata));

    // =====================================================================
    // Shared helpers
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp,
                           input string what);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_mode(input motor_cmd_pkg::motion_mode_t got,
                            input motor_cmd_pkg::motion_mode_t exp);
        chk_val(32'(got), 32'(exp), "mode");
    endtask

    task automatic ticks(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // Counts start pulses over n cycles and keeps the mode shown with one.
    task automatic watch(input int n);
        pulses = 0;
        repeat (n) begin
            @(negedge mclk);
            if (mstart === 1'b1) begin
                pulses++;
                pmode = mode;
            end
        end
    endtask

    task automatic summarize();
        if (err_total == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // =====================================================================
    // Scenarios
    // Walks one status input at a time, so a swapped bit cannot hide.
    task automatic t_status();
        logic [6:0] v;
        logic [15:0] e;
        io_word = 16'h0000;
        for (int i = 0; i < 7; i++) begin
            v = 7'(1 << i);
            {warning, in_area, ready, alarm, home_fin, moving, step_loss} = v;
            ticks(2);
            e = {v[3], v[6], 6'h00, v[5], 1'h0, v[4], v[3], v[2], v[1],
                 v[0], 1'h0};
            chk_val(io_out, e, "status");
        end
        {warning, in_area, ready, alarm, home_fin, moving, step_loss} = 7'h00;
        // Energised and started, but not ready: nothing may move.
        io_word = 16'h2A21;
        watch(2);
        chk_val(io_out, 16'h2A01, "echo");
        chk_val(pulses, 0, "no move");
        io_word = BASE;
        ready = 1'b1;
        ticks(3);
    endtask

    // A retrigger while busy must be ignored and not change the answer.
    task automatic run_cmd(input logic [13:0] code, input logic [31:0] data,
                           input bit retrig);
        int n;
        n = 0;
        cmd_code = code;
        cmd_data = data;
        cmd_cmd_trigger = 1'b1;
        ticks(2);
        chk_val(done_cmd_trigger, 0, "done busy");
        chk_val(ex_req, 1, "request");
        chk_val(ex_code, code, "code out");
        chk_val(ex_wdata, data, "wdata out");
        if (retrig) begin
            cmd_cmd_trigger = 1'b0;
            ticks(1);
            cmd_code = code ^ 14'h0001;
            cmd_cmd_trigger = 1'b1;
        end
        while (done_cmd_trigger !== 1'b1 && n < 20) begin
            ticks(1);
            n++;
        end
        chk_val(done_cmd_trigger, 1, "done");
        chk_val(rsp_code, code, "rsp code");
        chk_val(rsp_err, code[13], "result");
        chk_val(rsp_data, data + {18'h0, code}, "rsp data");
        cmd_cmd_trigger = 1'b0;
        ticks(2);
    endtask

    // Sets the select number, raises start, then judges the pulse and mode.
    task automatic start_move(input logic [5:0] sel, input int npulse,
                              input motor_cmd_pkg::motion_mode_t exp);
        io_word[13:8] = sel;
        ticks(2);
        io_word[0] = 1'b1;
        watch(4);
        chk_val(pulses, npulse, "pulses");
        if (npulse > 0) begin
            chk_mode(pmode, exp);
        end
        chk_val(dsel, sel, "select");
        io_word[0] = 1'b0;
        ticks(2);
    endtask

    task automatic t_continuous();
        io_word = BASE | 16'h0002;
        ticks(3);
        chk_mode(mode, motor_cmd_pkg::MODE_CONT_POS);
        io_word = BASE | 16'h0006;
        ticks(2);
        chk_mode(mode, motor_cmd_pkg::MODE_IDLE);
        io_word = BASE | 16'h0004;
        ticks(3);
        io_word[0] = 1'b1;
        watch(4);
        chk_val(pulses, 0, "start in run");
        chk_mode(mode, motor_cmd_pkg::MODE_CONT_NEG);
        io_word = BASE;
        ticks(2);
        chk_mode(mode, motor_cmd_pkg::MODE_IDLE);
    endtask

    // Home held high for many cycles must start only one move, and the
    // homing mode stands while the generator still reports motion.
    task automatic t_home();
        moving = 1'b1;
        io_word[3] = 1'b1;
        watch(8);
        chk_val(pulses, 1, "home pulses");
        chk_mode(pmode, motor_cmd_pkg::MODE_HOMING);
        chk_mode(mode, motor_cmd_pkg::MODE_HOMING);
        moving = 1'b0;
        io_word[3] = 1'b0;
        ticks(2);
        chk_mode(mode, motor_cmd_pkg::MODE_IDLE);
    endtask

    task automatic t_priority();
        for (int k = 0; k < 4; k++) begin
            stop_act = 2'(k);
            io_word = BASE | 16'h0010;
            ticks(2);
            chk_val(stop_o, 1, "stop");
            chk_val(stop_meth, k, "stop method");
        end
        start_move(6'h01, 0, motor_cmd_pkg::MODE_IDLE);
        io_word = 16'h0000;
        ticks(2);
        chk_val({stop_o, excite}, 0, "released");
        start_move(6'h01, 0, motor_cmd_pkg::MODE_IDLE);
        invert = 1'b1;
        ticks(2);
        chk_val(excite, 1, "inverted");
        start_move(6'h02, 1, motor_cmd_pkg::MODE_POSITION);
        invert = 1'b0;
        io_word = BASE;
        ready = 1'b0;
        ticks(2);
        chk_val(io_out[5], 0, "not ready");
        start_move(6'h02, 0, motor_cmd_pkg::MODE_IDLE);
        ready = 1'b1;
    endtask

    // =====================================================================
    // Main sequence
    initial begin
        {rst, ready} = 2'h3;
        {invert, moving, home_fin, step_loss, alarm, warning} = 6'h00;
        {in_area, cmd_cmd_trigger, stop_act, pulses} = 0;
        {io_word, cmd_code, cmd_data} = 0;
        ticks(12);
        rst = 1'b0;
        ticks(2);
        t_status();
        run_cmd(motor_cmd_pkg::STOP_ACTION_CODE, 32'h12345678,
                1'b0);
        run_cmd(14'h3E80, 32'hA1B2C3D4, 1'b1);
        start_move(6'h05, 1, motor_cmd_pkg::MODE_POSITION);
        start_move(6'h00, 1, motor_cmd_pkg::MODE_SEQUENCE);
        start_move(6'h3F, 1, motor_cmd_pkg::MODE_POSITION);
        t_continuous();
        t_home();
        t_priority();
        summarize();
    end

    // The tests need about 140 cycles; 5000 leaves ample margin.
    initial begin
        #(100 * 5000);
        err_total++;
        summarize();
    end
endmodule // motor_remote_io_command_port_tb

`default_nettype wire
